// *** dactc_top.sv ***
// Purpose: APB register slave and control for a two-channel 8-bit converter.
// Assumes: Standby is a level from the power controller on the same clock.
// Notes:   Module stop is set at reset and gates register access.
`timescale 1ns/100ps

// Operation
// RL1 - Control bit 7 enables channel 3 conversion and output when set, disables output when clear.
// RL2 - Control bit 6 enables channel 2 conversion and output when set, disables output when clear.
// RL3 - With joint enable clear each channel converts according to its own output enable.
// RL4 - With joint enable set both channels convert when channel 2 is enabled, none when both clear.
// RL5 - With joint enable and channel 3 enable set both channels convert.
// RL6 - Each analog pin is driven only according to its own output enable.
// RL7 - Control bits 4 to 0 read as one and ignore writes.
// RL8 - Setting an output enable starts conversion, the result appearing after the conversion time.
// RL9 - A result is held until its code is rewritten or its output enable is cleared.
// RL10 - The stored code is passed unchanged to the converter.
// RL11 - Writing a code while converting restarts conversion at once.
// RL12 - Clearing an output enable disables that output at once.
// RL13 - After reset module stop halts the converter and blocks register access until released.
// RL14 - In standby an enabled converter holds its output and conversion state.
// RL15 - Software clears both enables and the joint enable before standby for low current.
// RL16 - Each code register is 8-bit read/write and converted while its output is enabled.
// RL17 - Conversion time is a cycle count after which a per-channel valid is raised.
module dactc_top #(
   parameter int CONV_CYCLES = dactc_pkg::CONVERSION_CYCLES
) (
   input  wire logic        pclk,          // Peripheral clock, 25 MHz.
   input  wire logic        presetn,       // Asynchronous reset, active low.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB enable.
   input  wire logic        pwrite,        // APB write.
   input  wire logic [7:0]  paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   input  wire logic [3:0]  pstrb,         // APB byte strobes.
   output logic [31:0]      prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error.
   input  wire logic        standby,       // Software standby level.
   output logic [7:0]       ch2_analog_out, // Channel 2 code to converter.
   output logic [7:0]       ch3_analog_out, // Channel 3 code to converter.
   output logic             ch2_drive,     // Channel 2 pin drive.
   output logic             ch3_drive,     // Channel 3 pin drive.
   output logic             ch2_valid,     // Channel 2 result ready.
   output logic             ch3_valid      // Channel 3 result ready.
);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0]  ch2_code_q, ch2_code_d, ch3_code_q, ch3_code_d;
   logic        ch3_output_enable_q, ch3_output_enable_d;
   logic        ch2_output_enable_q, ch2_output_enable_d;
   logic        joint_conversion_enable_q, joint_conversion_enable_d;
   logic        module_stop_q, module_stop_d;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;
   logic        start2_q, start2_d, start3_q, start3_d;
   logic        access, wr, addr_ok, blocked;
   logic [7:0]  control_view;
   logic        conv2, conv3, run2, run3;
   logic [7:0]  code2_w, code3_w;
   logic        drive2_w, drive3_w, valid2_w, valid3_w;

   assign access  = psel && penable && !pready;
   assign wr      = access && pwrite && pstrb[0];
   assign addr_ok = paddr == dactc_pkg::CH2_CODE_OFFSET
                 || paddr == dactc_pkg::CH3_CODE_OFFSET
                 || paddr == dactc_pkg::CONTROL_OFFSET
                 || paddr == dactc_pkg::MODULE_STOP_OFFSET
                 || paddr == dactc_pkg::STATUS_OFFSET;
   assign blocked = module_stop_q && paddr != dactc_pkg::MODULE_STOP_OFFSET;      // [RL13]
   assign control_view = {ch3_output_enable_q, ch2_output_enable_q,
                          joint_conversion_enable_q, dactc_pkg::RESERVED_READ_VALUE}; // [RL7]

   // -----------------------------------------------------------------
   // Conversion enable decode
   // -----------------------------------------------------------------
   always_comb begin
      if (joint_conversion_enable_q) begin
         conv2 = ch2_output_enable_q || ch3_output_enable_q;   // [RL4] [RL5]
         conv3 = conv2;
      end else begin
         conv2 = ch2_output_enable_q;                          // [RL2] [RL3]
         conv3 = ch3_output_enable_q;                          // [RL1] [RL3]
      end
      run2 = conv2 && !module_stop_q;                          // [RL13]
      run3 = conv3 && !module_stop_q;
   end

   // -----------------------------------------------------------------
   // Bus slave next state
   // -----------------------------------------------------------------
   always_comb begin
      ch2_code_d                = ch2_code_q;
      ch3_code_d                = ch3_code_q;
      ch3_output_enable_d       = ch3_output_enable_q;
      ch2_output_enable_d       = ch2_output_enable_q;
      joint_conversion_enable_d = joint_conversion_enable_q;
      module_stop_d             = module_stop_q;
      start2_d                  = 1'b0;
      start3_d                  = 1'b0;
      pready_d                  = access;
      pslverr_d                 = access && (!addr_ok || blocked);
      prdata_d                  = 32'h0000_0000;
      if (wr && addr_ok && !blocked) begin
         case (paddr)
            dactc_pkg::CH2_CODE_OFFSET: begin
               ch2_code_d = pwdata[7:0];                       // [RL16]
               start2_d   = 1'b1;                              // [RL11]
            end
            dactc_pkg::CH3_CODE_OFFSET: begin
               ch3_code_d = pwdata[7:0];                       // [RL16]
               start3_d   = 1'b1;                              // [RL11]
            end
            dactc_pkg::CONTROL_OFFSET: begin
               // A rising output enable restarts a channel already running jointly.
               start3_d = pwdata[dactc_pkg::CH3_OE_BIT] && !ch3_output_enable_q; // [RL8]
               start2_d = pwdata[dactc_pkg::CH2_OE_BIT] && !ch2_output_enable_q; // [RL8]
               ch3_output_enable_d       = pwdata[dactc_pkg::CH3_OE_BIT];
               ch2_output_enable_d       = pwdata[dactc_pkg::CH2_OE_BIT];
               joint_conversion_enable_d = pwdata[dactc_pkg::JOINT_EN_BIT];
            end
            dactc_pkg::MODULE_STOP_OFFSET: module_stop_d = pwdata[0];
            default: module_stop_d = module_stop_q;
         endcase
      end
      if (access && !pwrite && addr_ok && !blocked) begin
         case (paddr)
            dactc_pkg::CH2_CODE_OFFSET:    prdata_d = {24'h000000, ch2_code_q};
            dactc_pkg::CH3_CODE_OFFSET:    prdata_d = {24'h000000, ch3_code_q};
            dactc_pkg::CONTROL_OFFSET:     prdata_d = {24'h000000, control_view};
            dactc_pkg::MODULE_STOP_OFFSET: prdata_d = {31'h00000000, module_stop_q};
            dactc_pkg::STATUS_OFFSET:
               prdata_d = {28'h0000000, ch3_valid, ch2_valid, ch3_drive, ch2_drive};
            default:                       prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch2_code_q                <= dactc_pkg::CODE_RESET;
         ch3_code_q                <= dactc_pkg::CODE_RESET;
         ch3_output_enable_q       <= 1'b0;
         ch2_output_enable_q       <= 1'b0;
         joint_conversion_enable_q <= 1'b0;
         module_stop_q             <= dactc_pkg::MODULE_STOP_RESET;
         start2_q                  <= 1'b0;
         start3_q                  <= 1'b0;
         prdata                    <= 32'h0000_0000;
         pready                    <= 1'b0;
         pslverr                   <= 1'b0;
      end else begin
         ch2_code_q                <= ch2_code_d;
         ch3_code_q                <= ch3_code_d;
         ch3_output_enable_q       <= ch3_output_enable_d;
         ch2_output_enable_q       <= ch2_output_enable_d;
         joint_conversion_enable_q <= joint_conversion_enable_d;
         module_stop_q             <= module_stop_d;
         start2_q                  <= start2_d;
         start3_q                  <= start3_d;
         prdata                    <= prdata_d;
         pready                    <= pready_d;
         pslverr                   <= pslverr_d;
      end
   end

   // -----------------------------------------------------------------
   // Channels
   // -----------------------------------------------------------------
   dactc_channel #(.CONV_CYCLES(CONV_CYCLES)) u_ch2 (
      .pclk          (pclk),
      .presetn       (presetn),
      .conv_enable   (run2),
      .output_enable (ch2_output_enable_q && !module_stop_q),   // [RL6]
      .start         (start2_q),
      .hold          (standby),                                 // [RL14]
      .code          (ch2_code_q),
      .analog_code   (code2_w),
      .drive         (drive2_w),
      .valid         (valid2_w)
   );

   dactc_channel #(.CONV_CYCLES(CONV_CYCLES)) u_ch3 (
      .pclk          (pclk),
      .presetn       (presetn),
      .conv_enable   (run3),
      .output_enable (ch3_output_enable_q && !module_stop_q),   // [RL6]
      .start         (start3_q),
      .hold          (standby),                                 // [RL14]
      .code          (ch3_code_q),
      .analog_code   (code3_w),
      .drive         (drive3_w),
      .valid         (valid3_w)
   );

   // Channel outputs are already flip-flops inside the channel module.
   assign ch2_analog_out = code2_w;                              // [RL10]
   assign ch3_analog_out = code3_w;
   assign ch2_drive      = drive2_w;
   assign ch3_drive      = drive3_w;
   assign ch2_valid      = valid2_w;
   assign ch3_valid      = valid3_w;

endmodule

// *** dactc_pkg.sv ***
// Purpose: Shared constants for the two-channel converter control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package dactc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] CH2_CODE_OFFSET      = 8'h00;
   localparam logic [7:0] CH3_CODE_OFFSET      = 8'h04;
   localparam logic [7:0] CONTROL_OFFSET       = 8'h08;
   localparam logic [7:0] MODULE_STOP_OFFSET   = 8'h0c;
   localparam logic [7:0] STATUS_OFFSET        = 8'h10;

   // -----------------------------------------------------------------
   // Control register fields
   // -----------------------------------------------------------------
   localparam int         CH3_OE_BIT           = 7;
   localparam int         CH2_OE_BIT           = 6;
   localparam int         JOINT_EN_BIT         = 5;
   localparam logic [4:0] RESERVED_READ_VALUE  = 5'h1f;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] CODE_RESET           = 8'h00;
   localparam logic       MODULE_STOP_RESET    = 1'b1;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int         CLOCK_HZ             = 25000000;
   localparam int         CONVERSION_TIME_NS   = 10000;
   localparam int         CONVERSION_CYCLES    =
      (CONVERSION_TIME_NS * (CLOCK_HZ / 1000000) + 999) / 1000;

endpackage

// *** dactc_channel.sv ***
// Purpose: One converter channel: conversion timer and output hold.
// Assumes: Start is a one-cycle pulse on the peripheral clock.
// Notes:   The code is passed to the analog side unchanged.
`timescale 1ns/100ps
module dactc_channel #(
   parameter int CONV_CYCLES = dactc_pkg::CONVERSION_CYCLES
) (
   input  wire logic       pclk,          // Peripheral clock.
   input  wire logic       presetn,       // Asynchronous reset, active low.
   input  wire logic       conv_enable,   // Conversion enabled for this channel.
   input  wire logic       output_enable, // Own output enable bit.
   input  wire logic       start,         // Restart conversion pulse.
   input  wire logic       hold,          // Freeze state (standby).
   input  wire logic [7:0] code,          // Stored code.
   output logic [7:0]      analog_code,   // Code presented to the converter.
   output logic            drive,         // Analog pin drive enable.
   output logic            valid          // Converted result is at the pin.
);

   if (CONV_CYCLES < 1) begin : g_bad_conv_cycles
      $error("CONV_CYCLES must be at least one");
   end

   localparam int CW = $clog2(CONV_CYCLES + 1);

   typedef enum logic [1:0] {IDLE, CONVERTING, HOLDING} dactc_chan_state_type;

   dactc_chan_state_type state_q, state_d;
   logic [CW-1:0]        count_q, count_d;
   logic [7:0]           code_q, code_d;
   logic                 drive_d, valid_d;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      code_d  = code_q;
      drive_d = output_enable;                                // [RL6] [RL12]
      valid_d = 1'b0;
      if (hold) begin
         state_d = state_q;                                    // [RL14]
         drive_d = drive;
      end else if (!conv_enable) begin
         state_d = IDLE;
         count_d = '0;
      end else if (start || state_q == IDLE) begin
         state_d = CONVERTING;                                 // [RL8] [RL11]
         count_d = CW'(CONV_CYCLES);                           // [RL17]
         code_d  = code;                                       // [RL10]
      end else if (state_q == CONVERTING) begin
         if (count_q == CW'(1)) state_d = HOLDING;
         count_d = count_q - CW'(1);
      end
      case (state_d)
         HOLDING: valid_d = drive_d;                           // [RL9]
         default: valid_d = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= IDLE;
         count_q     <= '0;
         code_q      <= dactc_pkg::CODE_RESET;
         drive       <= 1'b0;
         valid       <= 1'b0;
      end else begin
         state_q     <= state_d;
         count_q     <= count_d;
         code_q      <= code_d;
         drive       <= drive_d;
         valid       <= hold ? valid : valid_d;
      end
   end

   assign analog_code = code_q;

endmodule

// *** dactc_top_assertions.sv ***
// Purpose: Port-level checks for the converter control block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Bound to the top module from the testbench.
`timescale 1ns/100ps
module dactc_top_assertions #(
   parameter int CONV_CYCLES = dactc_pkg::CONVERSION_CYCLES
) (
   input wire logic        pclk,           // Clock.
   input wire logic        presetn,        // Reset, active low.
   input wire logic        psel,           // APB select.
   input wire logic        penable,        // APB enable.
   input wire logic        pwrite,         // APB write.
   input wire logic [7:0]  paddr,          // APB address.
   input wire logic [31:0] pwdata,         // APB write data.
   input wire logic [3:0]  pstrb,          // APB strobes.
   input wire logic [31:0] prdata,         // APB read data.
   input wire logic        pready,         // APB ready.
   input wire logic        pslverr,        // APB error.
   input wire logic        standby,        // Standby level.
   input wire logic [7:0]  ch2_analog_out, // Channel 2 code.
   input wire logic [7:0]  ch3_analog_out, // Channel 3 code.
   input wire logic        ch2_drive,      // Channel 2 drive.
   input wire logic        ch3_drive,      // Channel 3 drive.
   input wire logic        ch2_valid,      // Channel 2 valid.
   input wire logic        ch3_valid       // Channel 3 valid.
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // Cycles channel 2 has been driven and converting
   // ----------------------------------------------------------------
   logic [15:0] run_q;
   logic [15:0] run_d;

   always_comb begin
      run_d = run_q;
      if (!ch2_drive || ch2_valid) begin
         run_d = 16'h0000;
      end else if (!standby) begin
         run_d = run_q + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 16'h0000;
      end else begin
         run_q <= run_d;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

   property p_rd_upper;
      pready && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");

   property p_ch2_valid_drive;
      ch2_valid |-> ch2_drive;
   endproperty
   a_ch2_valid_drive: assert property (p_ch2_valid_drive) else $error("ch2 valid undriven");

   property p_ch3_valid_drive;
      ch3_valid |-> ch3_drive;
   endproperty
   a_ch3_valid_drive: assert property (p_ch3_valid_drive) else $error("ch3 valid undriven");

   property p_hold;
      ch2_valid && $past(ch2_valid) |-> $stable(ch2_analog_out);
   endproperty
   a_hold: assert property (p_hold) else $error("ch2 code changed while held");

   property p_standby;
      standby && $past(standby) |-> $stable(ch2_analog_out) && $stable(ch2_valid)
         && $stable(ch3_valid) && $stable(ch3_analog_out);
   endproperty
   a_standby: assert property (p_standby) else $error("state moved in standby");

   property p_conv_time;
      $rose(ch2_valid) |-> run_q >= 16'(CONV_CYCLES - 1);
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("ch2 valid too early");
endmodule

// *** dactc_analog_model.sv ***
// Purpose: Behavioural model of the two analog output stages.
// Assumes: Codes and drive come from the control block.
// Notes:   A level of zero stands for a disabled pin or a result not yet valid.
`timescale 1ns/100ps
module dactc_analog_model (
   input wire logic [7:0] ch2_code,  // Channel 2 code.
   input wire logic [7:0] ch3_code,  // Channel 3 code.
   input wire logic       ch2_drive, // Channel 2 drive.
   input wire logic       ch3_drive, // Channel 3 drive.
   input wire logic       ch2_valid, // Channel 2 result ready.
   input wire logic       ch3_valid, // Channel 3 result ready.
   output logic [7:0]     ch2_level, // Channel 2 level in steps of one 256th.
   output logic [7:0]     ch3_level  // Channel 3 level in steps of one 256th.
);
   assign ch2_level = (ch2_drive && ch2_valid) ? ch2_code : 8'h00;
   assign ch3_level = (ch3_drive && ch3_valid) ? ch3_code : 8'h00;
endmodule

// *** dactc_top_tb.sv ***
// Purpose: Self-checking bench for the converter control block.
// Assumes: APB slave answers one cycle after taking a request.
// Notes:   Conversion time is shortened to four cycles.
`timescale 1ns/100ps
bind dactc_top dactc_top_assertions #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .standby(standby), .ch2_analog_out(ch2_analog_out),
   .ch3_analog_out(ch3_analog_out), .ch2_drive(ch2_drive), .ch3_drive(ch3_drive),
   .ch2_valid(ch2_valid), .ch3_valid(ch3_valid));
module dactc_top_tb;
   localparam int CONV = 4;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        standby = 1'b0;
   logic [7:0]  c2, c3, l2, l3;
   logic        d2, d3, v2, v3;
   logic [31:0] rdv;
   logic        erv;
   int          failures = 0;
   int          n_compared = 0;

   always #20 pclk = ~pclk;

   dactc_top #(.CONV_CYCLES(CONV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
      .ch2_analog_out(c2), .ch3_analog_out(c3), .ch2_drive(d2), .ch3_drive(d3),
      .ch2_valid(v2), .ch3_valid(v3));
   dactc_analog_model i_model (.ch2_code(c2), .ch3_code(c3), .ch2_drive(d2),
      .ch3_drive(d3), .ch2_valid(v2), .ch3_valid(v3), .ch2_level(l2), .ch3_level(l3));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         $display("[ERR] pready expected 1 seen %b", pready);
         failures++;
         print_verdict();
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      apb(1'b1, a, d);
      chk("write error", 32'(ee), 32'(erv));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ee);
      apb(1'b0, a, 32'h0);
      chk("read error", 32'(ee), 32'(erv));
      chk("read data", ex, rdv);
   endtask

   task automatic wait_valid(input logic e2, input logic e3);
      int n;
      for (n = 0; n < 60 && !(v2 === e2 && v3 === e3); n++) @(posedge pclk);
      if (n >= 60) begin
         $display("[ERR] valid expected %b%b seen %b%b", e2, e3, v2, v3);
         failures++;
         print_verdict();
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [2:0] m;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(dactc_pkg::CONTROL_OFFSET, 32'h0, 1'b1);
      wr(dactc_pkg::MODULE_STOP_OFFSET, 32'h0, 1'b0);
      rd(dactc_pkg::MODULE_STOP_OFFSET, 32'h0, 1'b0);
      rd(dactc_pkg::CONTROL_OFFSET, 32'h1f, 1'b0);
      wr(dactc_pkg::CONTROL_OFFSET, 32'hff, 1'b0);
      rd(dactc_pkg::CONTROL_OFFSET, 32'hff, 1'b0);
      wr(dactc_pkg::CONTROL_OFFSET, 32'h00, 1'b0);
      wr(8'h14, 32'h0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         wr(dactc_pkg::CH2_CODE_OFFSET, 32'ha0 + i, 1'b0);
         wr(dactc_pkg::CH3_CODE_OFFSET, 32'h50 + i, 1'b0);
         rd(dactc_pkg::CH2_CODE_OFFSET, 32'ha0 + i, 1'b0);
         wr(dactc_pkg::CONTROL_OFFSET, {24'h0, m, 5'h00}, 1'b0);
         settle(1);
         chk("ch2 valid early", 32'h0, 32'(v2));
         wait_valid(m[1], m[2]);
         settle(1);
         chk("ch2 drive", 32'(m[1]), 32'(d2));
         chk("ch3 drive", 32'(m[2]), 32'(d3));
         chk("ch2 level", m[1] ? 32'ha0 + i : 32'h0, 32'(l2));
         chk("ch3 level", m[2] ? 32'h50 + i : 32'h0, 32'(l3));
         wr(dactc_pkg::CONTROL_OFFSET, 32'h0, 1'b0);
         settle(1);
         chk("ch2 drive off", 32'h0, 32'(d2));
         chk("ch3 drive off", 32'h0, 32'(d3));
      end
      wr(dactc_pkg::CONTROL_OFFSET, 32'ha0, 1'b0);
      wait_valid(1'b0, 1'b1);
      wr(dactc_pkg::CONTROL_OFFSET, 32'he0, 1'b0);
      settle(2);
      chk("ch2 valid on enable", 32'h0, 32'(v2));
      wait_valid(1'b1, 1'b1);
      wr(dactc_pkg::CONTROL_OFFSET, 32'h40, 1'b0);
      wait_valid(1'b1, 1'b0);
      rd(dactc_pkg::STATUS_OFFSET, 32'h5, 1'b0);
      wr(dactc_pkg::CH2_CODE_OFFSET, 32'h3c, 1'b0);
      settle(2);
      chk("ch2 valid restart", 32'h0, 32'(v2));
      wait_valid(1'b1, 1'b0);
      settle(1);
      chk("ch2 level new", 32'h3c, 32'(l2));
      @(posedge pclk);
      standby <= 1'b1;
      apb(1'b1, dactc_pkg::CH2_CODE_OFFSET, 32'h99);
      settle(10);
      chk("ch2 level standby", 32'h3c, 32'(l2));
      chk("ch2 valid standby", 32'h1, 32'(v2));
      @(posedge pclk);
      standby <= 1'b0;
      wr(dactc_pkg::CONTROL_OFFSET, 32'h0, 1'b0);
      settle(2);
      chk("ch2 drive end", 32'h0, 32'(d2));
      print_verdict();
   end
endmodule
